// File: mpg_irq_out.sv
// interrupt flags, buffer transfer and phase output selection
`timescale 1ns/10ps
module mpg_irq_out (
	input  wire logic                   clk_sys,
	input  wire logic                   reset,
	// pins
	input  wire logic [2:0]             rotor_position_inputs,
	input  wire logic                   emergency_shutdown_input,
	input  wire logic                   reload_timer_input_pin,
	output logic      [5:0]             phase_out_pins,
	output logic      [5:0]             phase_out_pins_oe,
	// timer and pulse sources
	input  wire logic                   pulse_generator_timer,
	input  wire logic [15:0]            timer_count,
	input  wire logic [15:0]            compare_clear_value,
	input  wire logic                   reload_timer_underflow,
	output logic                        reload_timer_count_in,
	// configuration
	input  wire logic [5:0]             phase_output_enables,
	input  wire logic [2:0]             write_source_select,
	input  wire logic                   position_compare_enable,
	input  wire logic [1:0]             position_edge_kind,
	input  wire logic [2:0]             compare_direction_field,
	input  wire logic [11:0]            shutdown_output_levels,
	input  wire logic                   write_timing_irq_enable,
	input  wire logic                   compare_clear_irq_enable,
	input  wire logic                   position_detect_irq_enable,
	input  wire logic                   compare_match_irq_enable,
	input  wire logic                   shutdown_irq_enable,
	// software access to the buffer pairs
	input  wire logic                   buf_write,
	input  wire logic [3:0]             buf_index,
	input  wire logic [15:0]            buf_data,
	// flag clear, one bit per event
	input  wire mpg_pkg::mpg_evt_t      flag_clear,
	// status
	output mpg_pkg::mpg_evt_t           flags,
	output mpg_pkg::mpg_irq_t           irq,
	output logic [15:0]                 output_data,
	output logic                        write_timing_pulse
);
	logic [15:0]          output_buffer_pairs [mpg_pkg::BUF_PAIRS];
	logic [2:0]           rotor_s;
	logic                 shutdown_s;
	logic                 timer_in_s;
	logic [2:0]           rotor_prev_reg;
	logic                 sw_wt_reg;
	logic                 pos_wt;
	logic                 underflow_prev_reg;
	logic                 uf_pulse;
	logic                 pos_armed_reg;
	logic [3:0]           load_index;
	logic [2:0]           addr_field;
	logic                 cmp_match_now;
	logic                 cmp_match_prev_reg;
	mpg_pkg::mpg_evt_t    evt;

	// turn the select code and pulse level into a pin level
	function automatic logic sel_level(input logic [1:0] sel,
	                                   input logic pulse);
		case (sel)
			mpg_pkg::SEL_LOW:   sel_level = 1'b0;
			mpg_pkg::SEL_PULSE: sel_level = pulse;
			mpg_pkg::SEL_INV:   sel_level = ~pulse;
			default:            sel_level = 1'b1;
		endcase
	endfunction

	mpg_sync #(.W(5)) u_sync (
		.clk_sys (clk_sys),
		.reset   (reset),
		.d       ({rotor_position_inputs, emergency_shutdown_input,
		           reload_timer_input_pin}),
		.q       ({rotor_s, shutdown_s, timer_in_s})
	);

	// the synchronised pin drives the reload timer count input
	assign reload_timer_count_in = timer_in_s;

	assign addr_field = output_data[8+mpg_pkg::ADDR_LSB +: 3];

	// position detect: selected edge kind, gated by a level match with the address when compare is enabled
	always_comb begin
		logic [2:0] rise;
		logic [2:0] fall;
		rise = rotor_s & ~rotor_prev_reg;
		fall = ~rotor_s & rotor_prev_reg;
		pos_wt = 1'b0;
		case (position_edge_kind)
			mpg_pkg::EDGE_RISE: pos_wt = |rise;
			mpg_pkg::EDGE_FALL: pos_wt = |fall;
			mpg_pkg::EDGE_BOTH: pos_wt = |(rise | fall);
			default:            pos_wt = 1'b0;
		endcase
		if (position_compare_enable) begin
			pos_wt = pos_wt && (rotor_s == addr_field);
		end
	end

	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			rotor_prev_reg     <= 3'h0;
			underflow_prev_reg <= 1'b0;
			cmp_match_prev_reg <= 1'b0;
		end else begin
			rotor_prev_reg     <= rotor_s;
			underflow_prev_reg <= reload_timer_underflow;
			cmp_match_prev_reg <= cmp_match_now;
		end
	end

	assign uf_pulse = reload_timer_underflow & ~underflow_prev_reg;

	// a position event arms the underflow write timing in the chained mode
	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			pos_armed_reg <= 1'b0;
		end else if (pos_wt) begin
			pos_armed_reg <= 1'b1;
		end else if (uf_pulse) begin
			pos_armed_reg <= 1'b0;
		end
	end

	// software write to pair zero delayed one cycle
	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			sw_wt_reg <= 1'b0;
		end else begin
			sw_wt_reg <= buf_write && buf_index == 4'h0;
		end
	end

	// write timing source selection
	always_comb begin
		case (write_source_select)
			3'h0:       write_timing_pulse = sw_wt_reg;
			3'h1:       write_timing_pulse = uf_pulse;
			3'h2, 3'h6: write_timing_pulse = pos_wt;
			3'h3, 3'h7: write_timing_pulse = uf_pulse & pos_armed_reg;
			default:    write_timing_pulse = uf_pulse | pos_wt;
		endcase
	end

	// pair zero always in software mode, else bank bit and address
	assign load_index = (write_source_select == mpg_pkg::SRC_SW) ? 4'h0 :
		{output_data[8+mpg_pkg::BANK_BIT], addr_field};

	// buffer pairs written by software
	always_ff @(posedge clk_sys) begin
		if (buf_write && buf_index < 4'hC) begin
			output_buffer_pairs[buf_index] <= buf_data;
		end
	end

	// output data pair loaded on each write timing whose pair index is below 12
	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			output_data <= mpg_pkg::OUT_DATA_RST;
		end else if (write_timing_pulse && load_index < 4'hC) begin
			output_data <= output_buffer_pairs[load_index];
		end
	end

	assign cmp_match_now = (addr_field == compare_direction_field);

	// event sources
	always_comb begin
		evt.write_timing    = write_timing_pulse;
		evt.compare_clear   = (timer_count == compare_clear_value);
		evt.position_detect = pos_wt;
		evt.compare_match   = cmp_match_now & ~cmp_match_prev_reg;
		evt.shutdown        = ~shutdown_s;
	end

	// sticky flags, a set wins over a clear
	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			flags <= '0;
		end else begin
			flags <= evt | (flags & ~flag_clear);
		end
	end

	// three request lines, held while an enabled flag stays set
	always_comb begin
		irq.line_a = flags.shutdown & shutdown_irq_enable;
		irq.line_b = (flags.write_timing & write_timing_irq_enable) |
			(flags.compare_clear & compare_clear_irq_enable);
		irq.line_c = (flags.position_detect & position_detect_irq_enable) |
			(flags.compare_match & compare_match_irq_enable);
	end

	// phase outputs: select code, shutdown override, enable
	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			phase_out_pins    <= 6'h00;
			phase_out_pins_oe <= 6'h00;
		end else begin
			for (int i = 0; i < mpg_pkg::PHASES; i++) begin
				if (!shutdown_s) begin
					phase_out_pins[i] <= sel_level(
						shutdown_output_levels[2*i +: 2],
						1'b0);
				end else begin
					phase_out_pins[i] <= sel_level(
						output_data[2*i +: 2],
						pulse_generator_timer);
				end
			end
			phase_out_pins_oe <= (phase_output_enables == mpg_pkg::OUT_EN_ALL)
				? 6'h3F : 6'h00;
		end
	end
endmodule

// File: mpg_pkg.sv
// package of constants and types for the multi-pulse interrupt and output block
// Summary of operation
// - Writing all ones to the phase output enable field hands the six phase pins to the waveform logic whatever the port direction says.
// - The reload timer input pin feeds the 16-bit reload timer and its direction bit is kept at zero.
// - Each write timing pulse sets the write timing flag and, when enabled, requests an interrupt.
// - A match of the 16-bit timer with the compare clear value sets the compare clear flag and, when enabled, requests an interrupt.
// - A write timing from position detection sets the position detect flag and, when enabled, requests an interrupt.
// - Position detection fires on a selected edge kind of the rotor inputs, and with compare enabled only when they also match the address field.
// - A match of the output data address field with the compare direction field sets the compare match flag and, when enabled, requests an interrupt.
// - A low emergency shutdown input sets the shutdown flag and, when enabled, requests an interrupt.
// - Line A carries shutdown, line B write timing or compare clear, line C position detect or compare match.
// - Each write timing with a pair index below twelve loads the output data pair from that buffer pair and the phase outputs update one clock later.
// - Each phase output follows its select code: 00 low, 01 pulse, 10 inverted pulse, 11 high.
// - The shutdown input forces the phase outputs to a fixed level regardless of the output data.
// - With write source zero a software write to buffer pair zero makes the write timing and data lands one cycle later.
// - A low shutdown input stops the generator outputs.
package mpg_pkg;
	localparam int           PHASES      = 6;
	localparam int           BUF_PAIRS   = 12;
	localparam int           TMR_W       = 16;
	localparam logic [5:0]   OUT_EN_ALL  = 6'h3F;
	localparam logic [2:0]   SRC_SW      = 3'h0;
	localparam logic [15:0]  OUT_DATA_RST = 16'h0000;
	localparam logic [15:0]  TMR_RST     = 16'h0000;
	localparam logic [1:0]   SEL_LOW     = 2'h0;
	localparam logic [1:0]   SEL_PULSE   = 2'h1;
	localparam logic [1:0]   SEL_INV     = 2'h2;
	localparam logic [1:0]   SEL_HIGH    = 2'h3;
	// field positions inside the upper output data byte
	localparam int           ADDR_LSB    = 0;
	localparam int           BANK_BIT    = 3;
	// edge kind codes for position detect
	localparam logic [1:0]   EDGE_NONE   = 2'h0;
	localparam logic [1:0]   EDGE_RISE   = 2'h1;
	localparam logic [1:0]   EDGE_FALL   = 2'h2;
	localparam logic [1:0]   EDGE_BOTH   = 2'h3;

	typedef struct packed {
		logic write_timing;
		logic compare_clear;
		logic position_detect;
		logic compare_match;
		logic shutdown;
	} mpg_evt_t;

	typedef struct packed {
		logic line_a;
		logic line_b;
		logic line_c;
	} mpg_irq_t;
endpackage

// File: mpg_sync.sv
// three-stage input synchroniser with agreement filter
`timescale 1ns/10ps
module mpg_sync #(
	parameter int W = 1
) (
	input  wire logic         clk_sys,
	input  wire logic         reset,
	input  wire logic [W-1:0] d,
	output logic      [W-1:0] q
);
	logic [W-1:0] s1_reg;
	logic [W-1:0] s2_reg;
	logic [W-1:0] s3_reg;

	// shift chain, first stage feeds only the second
	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			s1_reg <= '0;
			s2_reg <= '0;
			s3_reg <= '0;
		end else begin
			s1_reg <= d;
			s2_reg <= s1_reg;
			s3_reg <= s2_reg;
		end
	end

	// output takes a bit only when stages two and three agree
	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			q <= '0;
		end else begin
			for (int i = 0; i < W; i++) begin
				if (s2_reg[i] == s3_reg[i]) begin
					q[i] <= s2_reg[i];
				end
			end
		end
	end
endmodule

// File: mpg_irq_out_sva.sv
// assertion checker for the interrupt and output block
`timescale 1ns/10ps
module mpg_irq_out_sva (
	input wire logic              clk_sys,
	input wire logic              reset,
	input wire logic              emergency_shutdown_input,
	input wire logic [15:0]       timer_count,
	input wire logic [15:0]       compare_clear_value,
	input wire logic [2:0]        write_source_select,
	input wire logic [2:0]        compare_direction_field,
	input wire logic              write_timing_irq_enable,
	input wire logic              compare_clear_irq_enable,
	input wire logic              shutdown_irq_enable,
	input wire logic              position_detect_irq_enable,
	input wire logic              compare_match_irq_enable,
	input wire logic [5:0]        phase_output_enables,
	input wire logic [5:0]        phase_out_pins_oe,
	input wire logic              buf_write,
	input wire logic [3:0]        buf_index,
	input wire logic [15:0]       buf_data,
	input wire mpg_pkg::mpg_evt_t flag_clear,
	input wire mpg_pkg::mpg_evt_t flags,
	input wire mpg_pkg::mpg_irq_t irq,
	input wire logic [15:0]       output_data,
	input wire logic              write_timing_pulse
);
	logic sw_wr;
	// software write to pair zero in software source mode
	assign sw_wr = buf_write && buf_index == 4'h0 && write_source_select == 3'h0;
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (reset);
	line_a_map_a: assert property (irq.line_a == (flags.shutdown &&
		shutdown_irq_enable)) else $error("line a wrong");
	line_b_map_a: assert property (irq.line_b == (flags.write_timing &&
		write_timing_irq_enable || flags.compare_clear &&
		compare_clear_irq_enable)) else $error("line b wrong");
	line_c_map_a: assert property (irq.line_c == (
		flags.position_detect && position_detect_irq_enable ||
		flags.compare_match && compare_match_irq_enable))
		else $error("line c wrong");
	pin_enable_a: assert property (!$past(reset) |->
		phase_out_pins_oe == {6{$past(phase_output_enables) == 6'h3F}})
		else $error("pin enable wrong");
	sw_pulse_a: assert property (sw_wr |=> write_timing_pulse)
		else $error("no write timing pulse");
	data_load_a: assert property (sw_wr ##1 !buf_write |=> ##1
		output_data == $past(buf_data, 3)) else $error("data not loaded");
	wt_flag_a: assert property (write_timing_pulse |=> flags.write_timing)
		else $error("write timing flag missing");
	cc_flag_a: assert property (timer_count == compare_clear_value |=>
		flags.compare_clear) else $error("compare clear flag missing");
	flag_sticky_a: assert property (1'b1 |=> ($past(flags) &
		~$past(flag_clear) & ~flags) == 5'h00) else $error("flag lost");
	sd_flag_a: assert property (!emergency_shutdown_input [*6] |=>
		flags.shutdown) else $error("shutdown flag missing");
	cmp_match_a: assert property ($rose(output_data[10:8] ==
		compare_direction_field) |-> ##[1:2] flags.compare_match)
		else $error("compare match flag missing");
endmodule
bind mpg_irq_out mpg_irq_out_sva u_sva (.*);

// File: mpg_motor_model.sv
// model of the rotor sensors and shutdown source facing the block
`timescale 1ns/10ps
module mpg_motor_model (
	input  wire logic [5:0] phase_out_pins,
	output logic      [2:0] rotor_position_inputs,
	output logic            emergency_shutdown_input,
	output logic            reload_timer_input_pin
);
	// sensors at rest, shutdown line held by its pull-up
	initial begin
		rotor_position_inputs = 3'h0;
		emergency_shutdown_input = 1'b1;
		reload_timer_input_pin = 1'b0;
	end
	// turn the rotor to a new sensor pattern
	task automatic rotor(input logic [2:0] p);
		rotor_position_inputs = p;
	endtask
	// drive the reload timer input pin
	task automatic spin(input logic v);
		reload_timer_input_pin = v;
	endtask
	// pull the shutdown line low or release it
	task automatic trip(input logic low);
		emergency_shutdown_input = !low;
	endtask
endmodule

// File: multipulse_irq_and_output_select_bench.sv
// self-checking bench for the interrupt and output block
`timescale 1ns/10ps
module multipulse_irq_and_output_select_bench;
	logic              clk_sys, reset, pgt, buf_write, esd, wtp;
	logic              tin, tcin;
	logic [2:0]        rot, cdir;
	logic [3:0]        bidx;
	logic [4:0]        en;
	logic [5:0]        pins, oe_en, oe;
	logic [15:0]       tcnt, ccv, d, odata;
	mpg_pkg::mpg_evt_t fclr, flags;
	mpg_pkg::mpg_irq_t irq;
	logic [15:0]       exp_q[$];
	int                n_fail = 0, samples_checked = 0;
	logic              seen = 1'b0;
	mpg_motor_model u_part (.phase_out_pins(pins),
		.rotor_position_inputs(rot), .emergency_shutdown_input(esd),
		.reload_timer_input_pin(tin));
	mpg_irq_out u_dut (.clk_sys(clk_sys), .reset(reset),
		.rotor_position_inputs(rot), .emergency_shutdown_input(esd),
		.reload_timer_input_pin(tin), .phase_out_pins(pins),
		.phase_out_pins_oe(oe), .pulse_generator_timer(pgt),
		.timer_count(tcnt), .compare_clear_value(ccv),
		.reload_timer_underflow(1'b0), .reload_timer_count_in(tcin),
		.phase_output_enables(oe_en), .write_source_select(3'h0),
		.position_compare_enable(1'b0),
		.position_edge_kind(mpg_pkg::EDGE_BOTH),
		.compare_direction_field(cdir), .shutdown_output_levels(12'hFFF),
		.write_timing_irq_enable(en[4]), .compare_clear_irq_enable(en[3]),
		.position_detect_irq_enable(en[2]),
		.compare_match_irq_enable(en[1]), .shutdown_irq_enable(en[0]),
		.buf_write(buf_write), .buf_index(bidx), .buf_data(d),
		.flag_clear(fclr), .flags(flags), .irq(irq), .output_data(odata),
		.write_timing_pulse(wtp));
	task automatic close_out();
		$display("checks %0d mismatches %0d", samples_checked, n_fail);
		if (n_fail == 0 && samples_checked > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		samples_checked++;
		if (got !== exp) begin
			n_fail++;
			$display("[FAIL] %0t got %h want %h", $time, got, exp);
		end
	endtask
	task automatic step(input int n);
		repeat (n) @(posedge clk_sys);
		#1;
	endtask
	// clear flags, then leave an edge before the next request
	task automatic clr(input logic [4:0] c);
		fclr = c;
		step(1);
		fclr = 5'h00;
		step(1);
	endtask
	// write pair zero and note the word it must load
	task automatic wr(input logic [15:0] v);
		d = v;
		buf_write = 1'b1;
		exp_q.push_back(v);
		step(1);
	endtask
	// pin level for each two-bit select code
	function automatic logic [5:0] sel(input logic [11:0] c, input logic p);
		for (int i = 0; i < 6; i++) sel[i] = c[2*i+1] ? c[2*i] | !p : c[2*i] & p;
	endfunction
	// compare each loaded word with the oldest note
	always @(negedge clk_sys) begin
		if (seen && exp_q.size() > 0) chk(odata, exp_q.pop_front());
		seen = wtp;
	end
	initial begin
		clk_sys = 1'b0;
		forever #50 clk_sys = ~clk_sys;
	end
	initial begin
		#(2000 * 100);
		n_fail++;
		close_out();
	end
	initial begin
		{reset, pgt, buf_write, d, fclr, en} = {3'b100, 16'h0, 5'h0, 5'h1F};
		{tcnt, ccv, cdir} = {16'h0001, 16'h8000, 3'h6};
		{bidx, oe_en} = {4'h0, 6'h3F};
		void'($urandom(32'hAA707ADA));
		step(8);
		reset = 1'b0;
		step(8);
		clr(5'h1F);
		chk({8'h00, flags, irq}, 16'h0000);
		chk({10'h0, oe}, 16'h003F);
		oe_en = 6'($urandom) & 6'h1F;
		step(1);
		chk({10'h0, oe}, 16'h0000);
		oe_en = 6'h3F;
		u_part.spin(1'b1);
		step(4);
		chk({15'h0, tcin}, 16'h0001);
		u_part.spin(1'b0);
		step(4);
		chk({15'h0, tcin}, 16'h0000);
		// writes to other pairs or past the last make no write timing
		d = 16'hFFFF;
		buf_write = 1'b1;
		bidx = 4'(1 + $urandom % 11);
		step(1);
		bidx = 4'hC + 4'($urandom % 4);
		step(1);
		buf_write = 1'b0;
		bidx = 4'h0;
		step(2);
		chk({8'h00, flags, irq}, 16'h0000);
		chk(odata, mpg_pkg::OUT_DATA_RST);
		repeat (6) wr({8'h08, 8'($urandom)});
		buf_write = 1'b0;
		for (int k = 0; k < 4; k++) begin
			pgt = 1'($urandom);
			wr({4'h1, {6{k[1:0]}}});
			buf_write = 1'b0;
			step(3);
			chk({10'h0, pins}, {10'h0, sel({6{k[1:0]}}, pgt)});
		end
		chk({8'h00, flags, irq}, 16'h0082);
		clr(5'h10);
		tcnt = ccv;
		step(1);
		tcnt = 16'h0001;
		step(1);
		chk({8'h00, flags, irq}, 16'h0042);
		en = 5'h17;
		step(1);
		chk({8'h00, flags, irq}, 16'h0040);
		en = 5'h1F;
		clr(5'h08);
		wr(16'h0600);
		buf_write = 1'b0;
		step(3);
		chk({8'h00, flags, irq}, 16'h0093);
		clr(5'h12);
		u_part.rotor(3'h5);
		step(6);
		chk({8'h00, flags, irq}, 16'h0021);
		clr(5'h04);
		u_part.trip(1'b1);
		step(6);
		chk({8'h00, flags, irq}, 16'h000C);
		chk({10'h0, pins}, 16'h003F);
		u_part.trip(1'b0);
		step(6);
		clr(5'h01);
		chk({8'h00, flags, irq}, 16'h0000);
		close_out();
	end
endmodule
